// file: hw/dbg_access_top.sv
// debug access block: serial debug port pins, tap, restart and debug i/o client
// assumes ahb-lite master on i_ref_clk and a tool-driven debug clock pin
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module dbg_access_top (
    // clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_sys_rst,
    // ahb-lite slave
    input  wire logic                      i_hsel,
    input  wire logic [31:0]               i_haddr,
    input  wire logic [1:0]                i_htrans,
    input  wire logic                      i_hwrite,
    input  wire logic [2:0]                i_hsize,
    input  wire logic [31:0]               i_hwdata,
    input  wire logic                      i_hready,
    output logic [31:0]                    o_hrdata,
    output logic                           o_hreadyout,
    output logic                           o_hresp,
    // serial debug port pins
    input  wire logic                      i_debug_clock_pin,
    input  wire logic                      i_debug_mode_pin,
    input  wire logic                      i_debug_data_pin,
    output logic                           o_debug_data_out,
    output logic                           o_debug_data_oe,
    // device outputs gate and application reset
    output logic                           o_outputs_disabled,
    input  wire logic                      i_app_rst,
    // triggered transfer bus side
    input  wire logic                      i_trigger,
    input  wire logic                      i_xfer_done,
    input  wire logic [31:0]               i_xfer_rdata,
    output logic                           o_xfer_req,
    output logic [31:0]                    o_xfer_src_addr,
    output logic [31:0]                    o_xfer_dst_addr,
    output logic [2:0]                     o_xfer_size
);
    import dbg_pkg::*;

    // pin synchronisers, first stage read only by second
    logic [2:0]  pin_s1_reg;
    logic [2:0]  pin_s2_reg;
    logic        clk_prev_reg;
    logic        tck_rise;
    logic        tck_fall;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pin_s1_reg   <= 3'h0;
            pin_s2_reg   <= 3'h0;
            clk_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg   <= {i_debug_data_pin, i_debug_mode_pin, i_debug_clock_pin};
            pin_s2_reg   <= pin_s1_reg;
            clk_prev_reg <= pin_s2_reg[0];
        end
    end
    assign tck_rise = pin_s2_reg[0] && !clk_prev_reg;
    assign tck_fall = !pin_s2_reg[0] && clk_prev_reg;

    // ahb-lite address phase capture
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic        addr_ok;
    logic        rd_take;
    logic        wr_take;

    assign addr_ok = (i_haddr[31:8] == 24'h000000) && (i_haddr[1:0] == 2'h0);
    assign rd_take = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    assign wr_take = i_hsel && i_hready && i_htrans[1] && i_hwrite;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= wr_take && addr_ok;
            wr_addr_reg <= i_haddr[7:0];
        end
    end

    // zero wait states and always okay
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    logic        wr_ctrl;
    logic        wr_cmd;
    logic        wr_src;
    logic        wr_dst;
    logic        wr_info;
    assign wr_ctrl = wr_pend_reg && (wr_addr_reg == DBG_CTRL_OFS);
    assign wr_cmd  = wr_pend_reg && (wr_addr_reg == DBG_CMD_OFS);
    assign wr_src  = wr_pend_reg && (wr_addr_reg == DBG_SRC_OFS);
    assign wr_dst  = wr_pend_reg && (wr_addr_reg == DBG_DST_OFS);
    assign wr_info = wr_pend_reg && (wr_addr_reg == DBG_INFO_OFS);

    // control: restart and boundary-scan lock
    logic        restart_reg;
    logic [1:0]  lock_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            restart_reg <= 1'b0;
            lock_reg    <= DBG_LOCK_RST;
        end else if (wr_ctrl) begin
            restart_reg <= i_hwdata[DBG_CTRL_RESTART_BIT];
            lock_reg    <= i_hwdata[DBG_CTRL_LOCK_LSB +: 2];
        end
    end

    // restart is held here and only sampled on a debug clock edge;
    // a clock that stands still while restart is high misses it
    logic        restart_tck;
    assign restart_tck = restart_reg;

    logic        tap_tdo;
    logic        tap_tdo_oe;
    logic [7:0]  tap_ir;
    logic        tap_in_reset;

    dbg_tap_ir u_tap (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_tck_rise (tck_rise),
        .i_tck_fall (tck_fall),
        .i_tms      (pin_s2_reg[1]),
        .i_tdi      (pin_s2_reg[2]),
        .i_restart  (restart_tck),
        .o_tdo      (tap_tdo),
        .o_tdo_oe   (tap_tdo_oe),
        .o_ir       (tap_ir),
        .o_in_reset (tap_in_reset)
    );

    // serial debug port state
    dbg_port_t   port_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            port_reg <= DBG_PORT_ENABLED;
        end else if (tck_rise && restart_tck) begin
            port_reg <= DBG_PORT_ENABLED;
        // only on a debug clock edge, so a restart is not undone a cycle later
        end else if (tck_rise && !tap_in_reset) begin
            port_reg <= DBG_PORT_ACTIVE;
        end
    end

    // boundary-scan effects blocked while the lock is nonzero
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_outputs_disabled <= 1'b0;
            o_debug_data_out   <= 1'b0;
            o_debug_data_oe    <= 1'b0;
        end else begin
            o_outputs_disabled <= (tap_ir == DBG_IR_INTEST) && (lock_reg == 2'h0);
            o_debug_data_out   <= tap_tdo;
            o_debug_data_oe    <= tap_tdo_oe;
        end
    end

    // debug i/o client
    logic [7:0]  conf_reg;
    logic        err_reg;
    logic        ars_reg;
    logic [3:0]  op;
    logic        cmd_ok;

    assign op     = i_hwdata[3:0];
    assign cmd_ok = wr_cmd && (!err_reg || op == DBG_OP_LEAVE_ERR);

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || i_app_rst) begin
            conf_reg <= DBG_CONF_RST;
        end else if (cmd_ok && op == DBG_OP_WR_CONF) begin
            conf_reg <= i_hwdata[DBG_CMD_ARG_LSB +: 8];
        end
    end

    // tool interaction suspended until leave-error
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            err_reg <= 1'b0;
        end else if (i_app_rst) begin
            err_reg <= 1'b1;
        end else if (wr_cmd && op == DBG_OP_LEAVE_ERR) begin
            err_reg <= 1'b0;
        end
    end

    // sticky, write one to clear; the set wins
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ars_reg <= 1'b0;
        end else if (i_app_rst) begin
            ars_reg <= 1'b1;
        end else if (wr_info && i_hwdata[DBG_INFO_ARS_BIT]) begin
            ars_reg <= 1'b0;
        end
    end

    // transfer addresses
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_xfer_src_addr <= 32'h00000000;
            o_xfer_dst_addr <= 32'h00000000;
        end else begin
            if (wr_src) begin
                o_xfer_src_addr <= i_hwdata;
            end
            if (wr_dst) begin
                o_xfer_dst_addr <= i_hwdata;
            end
        end
    end

    // triggered transfer: one word fetch per trigger arriving with no fetch pending and no word held
    logic        trig_mode;
    logic        valid_reg;
    logic        dirty_reg;
    logic        saved_dirty_reg;
    logic        rdirty_reg;
    logic [31:0] cap_reg;
    logic [31:0] rd_word_reg;
    logic        rd_word_cmd;
    logic        rd_trig_cmd;
    logic        missed;

    assign trig_mode   = conf_reg[DBG_CONF_TRIG_BIT];
    assign rd_word_cmd = cmd_ok && op == DBG_OP_RD_WORD;
    assign rd_trig_cmd = cmd_ok && op == DBG_OP_RD_TRIG;
    assign missed      = trig_mode && i_trigger && (valid_reg || o_xfer_req);

    // half-word select in conf is ignored: size is always a word
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_xfer_req  <= 1'b0;
            o_xfer_size <= DBG_SIZE_WORD;
        end else begin
            o_xfer_size <= DBG_SIZE_WORD;
            if (o_xfer_req && i_xfer_done) begin
                o_xfer_req <= 1'b0;
            end else if (trig_mode && i_trigger && !valid_reg) begin
                o_xfer_req <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            valid_reg <= 1'b0;
            cap_reg   <= 32'h00000000;
        end else if (o_xfer_req && i_xfer_done) begin
            valid_reg <= 1'b1;
            cap_reg   <= i_xfer_rdata;
        end else if (rd_word_cmd || rd_trig_cmd) begin
            valid_reg <= 1'b0;
        end
    end

    // a miss in the same cycle as a read still marks the data dirty
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            dirty_reg       <= 1'b0;
            saved_dirty_reg <= 1'b0;
        end else if (missed) begin
            dirty_reg <= 1'b1;
        end else if (rd_word_cmd) begin
            dirty_reg       <= 1'b0;
            saved_dirty_reg <= dirty_reg;
        end else if (rd_trig_cmd) begin
            dirty_reg <= saved_dirty_reg;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rd_word_reg <= 32'h00000000;
            rdirty_reg  <= 1'b0;
        end else if (rd_word_cmd) begin
            rd_word_reg <= cap_reg;
            rdirty_reg  <= dirty_reg || missed;
        end
    end

    // read data prepared at the address phase for the data phase
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (!addr_ok) begin
            rd_mux = 32'h00000000;
        end else if (i_haddr[7:0] == DBG_CTRL_OFS) begin
            rd_mux = {29'h0, lock_reg, restart_reg};
        end else if (i_haddr[7:0] == DBG_STAT_OFS) begin
            rd_mux = {20'h0, o_outputs_disabled, tap_ir, tap_in_reset, port_reg};
        end else if (i_haddr[7:0] == DBG_CONF_OFS) begin
            rd_mux = {24'h0, conf_reg};
        end else if (i_haddr[7:0] == DBG_SRC_OFS) begin
            rd_mux = o_xfer_src_addr;
        end else if (i_haddr[7:0] == DBG_DST_OFS) begin
            rd_mux = o_xfer_dst_addr;
        end else if (i_haddr[7:0] == DBG_DATA_OFS) begin
            rd_mux = rd_word_reg;
        end else if (i_haddr[7:0] == DBG_INFO_OFS) begin
            rd_mux = {27'h0, rdirty_reg, valid_reg, dirty_reg, ars_reg, err_reg};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h00000000;
        end else if (rd_take) begin
            o_hrdata <= rd_mux;
        end
    end
endmodule

// file: hw/dbg_pkg.sv
// constants shared by the debug access block and its tap submodule
// assumes a word-wide ahb-lite register bus and a 10 mhz reference clock
package dbg_pkg;
    // register byte offsets
    localparam logic [7:0] DBG_CTRL_OFS   = 8'h00;
    localparam logic [7:0] DBG_STAT_OFS   = 8'h04;
    localparam logic [7:0] DBG_CONF_OFS   = 8'h08;
    localparam logic [7:0] DBG_CMD_OFS    = 8'h0c;
    localparam logic [7:0] DBG_SRC_OFS    = 8'h10;
    localparam logic [7:0] DBG_DST_OFS    = 8'h14;
    localparam logic [7:0] DBG_DATA_OFS   = 8'h18;
    localparam logic [7:0] DBG_INFO_OFS   = 8'h1c;
    // ctrl fields
    localparam int DBG_CTRL_RESTART_BIT   = 0;
    localparam int DBG_CTRL_LOCK_LSB      = 1;
    localparam logic [1:0] DBG_LOCK_RST   = 2'h1;
    // client configuration fields
    localparam int DBG_CONF_TRIG_BIT      = 0;
    localparam int DBG_CONF_HW_BIT        = 1;
    localparam logic [7:0] DBG_CONF_RST   = 8'h00;
    // info fields
    localparam int DBG_INFO_ERR_BIT       = 0;
    localparam int DBG_INFO_ARS_BIT       = 1;
    localparam int DBG_INFO_DIRTY_BIT     = 2;
    localparam int DBG_INFO_VALID_BIT     = 3;
    localparam int DBG_INFO_RDIRTY_BIT    = 4;
    // command field: opcode in [3:0], payload in [15:8]
    localparam int DBG_CMD_ARG_LSB        = 8;
    localparam logic [3:0] DBG_OP_LEAVE_ERR = 4'h1;
    localparam logic [3:0] DBG_OP_WR_CONF   = 4'h2;
    localparam logic [3:0] DBG_OP_RD_WORD   = 4'h3;
    localparam logic [3:0] DBG_OP_RD_TRIG   = 4'h4;
    // instruction register
    localparam int DBG_IR_W               = 8;
    localparam logic [7:0] DBG_IR_CAPTURE = 8'h01;
    localparam logic [7:0] DBG_IR_INTEST  = 8'h01;
    localparam logic [7:0] DBG_IR_RST     = 8'hff;
    // transfer size code for a whole word
    localparam logic [2:0] DBG_SIZE_WORD  = 3'h2;
    typedef enum logic [1:0] {DBG_PORT_ENABLED, DBG_PORT_ACTIVE} dbg_port_t;
endpackage

// file: hw/dbg_tap_ir.sv
// boundary-scan tap controller with 8-bit instruction register
// assumes edges of the debug clock pin arrive as one-cycle strobes
`timescale 1ns/1ns
module dbg_tap_ir (
    // clock and reset
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_sys_rst,
    // sampled pins
    input  wire logic                        i_tck_rise,
    input  wire logic                        i_tck_fall,
    input  wire logic                        i_tms,
    input  wire logic                        i_tdi,
    input  wire logic                        i_restart,
    // results
    output logic                             o_tdo,
    output logic                             o_tdo_oe,
    output logic [dbg_pkg::DBG_IR_W-1:0]     o_ir,
    output logic                             o_in_reset
);
    import dbg_pkg::*;
    typedef enum logic [3:0] {
        DBG_TLR, DBG_RTI, DBG_SEL_DR, DBG_CAP_DR, DBG_SH_DR, DBG_EX1_DR,
        DBG_PA_DR, DBG_EX2_DR, DBG_UPD_DR, DBG_SEL_IR, DBG_CAP_IR,
        DBG_SH_IR, DBG_EX1_IR, DBG_PA_IR, DBG_EX2_IR, DBG_UPD_IR
    } dbg_tap_t;
    dbg_tap_t              state_reg;
    dbg_tap_t              state_next;
    logic [DBG_IR_W-1:0]   shift_reg;
    logic                  bypass_reg;

    always_comb begin
        case (state_reg)
            DBG_TLR:    state_next = i_tms ? DBG_TLR    : DBG_RTI;
            DBG_RTI:    state_next = i_tms ? DBG_SEL_DR : DBG_RTI;
            DBG_SEL_DR: state_next = i_tms ? DBG_SEL_IR : DBG_CAP_DR;
            DBG_CAP_DR: state_next = i_tms ? DBG_EX1_DR : DBG_SH_DR;
            DBG_SH_DR:  state_next = i_tms ? DBG_EX1_DR : DBG_SH_DR;
            DBG_EX1_DR: state_next = i_tms ? DBG_UPD_DR : DBG_PA_DR;
            DBG_PA_DR:  state_next = i_tms ? DBG_EX2_DR : DBG_PA_DR;
            DBG_EX2_DR: state_next = i_tms ? DBG_UPD_DR : DBG_SH_DR;
            DBG_UPD_DR: state_next = i_tms ? DBG_SEL_DR : DBG_RTI;
            DBG_SEL_IR: state_next = i_tms ? DBG_TLR    : DBG_CAP_IR;
            DBG_CAP_IR: state_next = i_tms ? DBG_EX1_IR : DBG_SH_IR;
            DBG_SH_IR:  state_next = i_tms ? DBG_EX1_IR : DBG_SH_IR;
            DBG_EX1_IR: state_next = i_tms ? DBG_UPD_IR : DBG_PA_IR;
            DBG_PA_IR:  state_next = i_tms ? DBG_EX2_IR : DBG_PA_IR;
            DBG_EX2_IR: state_next = i_tms ? DBG_UPD_IR : DBG_SH_IR;
            DBG_UPD_IR: state_next = i_tms ? DBG_SEL_DR : DBG_RTI;
            default:    state_next = DBG_TLR;
        endcase
    end

    // restart only takes effect on a debug clock edge
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_reg <= DBG_TLR;
        end else if (i_tck_rise && i_restart) begin
            state_reg <= DBG_TLR;
        end else if (i_tck_rise) begin
            state_reg <= state_next;
        end
    end

    // shift, capture and update act on the rising edge in the current state
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            shift_reg  <= DBG_IR_CAPTURE;
            bypass_reg <= 1'b0;
        end else if (i_tck_rise && !i_restart) begin
            if (state_reg == DBG_CAP_IR) begin
                shift_reg <= DBG_IR_CAPTURE;
            end else if (state_reg == DBG_SH_IR) begin
                shift_reg <= {i_tdi, shift_reg[DBG_IR_W-1:1]};
            end
            if (state_reg == DBG_CAP_DR) begin
                bypass_reg <= 1'b0;
            end else if (state_reg == DBG_SH_DR) begin
                bypass_reg <= i_tdi;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_ir <= DBG_IR_RST;
        end else if (i_tck_rise && (i_restart || state_reg == DBG_TLR)) begin
            o_ir <= DBG_IR_RST;
        end else if (i_tck_rise && state_reg == DBG_UPD_IR) begin
            o_ir <= shift_reg;
        end
    end

    // output changes on the falling edge, so the tool samples it stable
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (i_tck_fall) begin
            o_tdo    <= (state_reg == DBG_SH_IR) ? shift_reg[0] : bypass_reg;
            o_tdo_oe <= (state_reg == DBG_SH_IR) || (state_reg == DBG_SH_DR);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_in_reset <= 1'b1;
        end else begin
            o_in_reset <= (state_reg == DBG_TLR);
        end
    end
endmodule

// file: tb/dbg_access_properties.sv
// port-level assertions for the debug access block
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
module dbg_access_properties
    import dbg_pkg::*;
(
    // clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    // register bus
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // debug pins
    input wire logic        i_debug_clock_pin,
    input wire logic        o_debug_data_out,
    input wire logic        o_outputs_disabled,
    input wire logic        o_debug_data_oe,
    // triggered transfer
    input wire logic        i_trigger,
    input wire logic        i_xfer_done,
    input wire logic        o_xfer_req,
    input wire logic [31:0] o_xfer_src_addr,
    input wire logic [2:0]  o_xfer_size
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    property p_okay; o_hreadyout && !o_hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
    property p_size; o_xfer_size == DBG_SIZE_WORD; endproperty
    a_size: assert property (p_size) else $error("transfer size not a word");
    property p_req_hold; o_xfer_req && !i_xfer_done |=> o_xfer_req; endproperty
    a_req_hold: assert property (p_req_hold) else $error("transfer request dropped early");
    property p_req_drop; o_xfer_req && i_xfer_done |=> !o_xfer_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("transfer request kept after done");
    property p_req_cause; $rose(o_xfer_req) |-> $past(i_trigger); endproperty
    a_req_cause: assert property (p_req_cause) else $error("transfer request without trigger");
    property p_rd_hold; !(i_hsel && i_hready && i_htrans[1] && !i_hwrite) |=> $stable(o_hrdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_rst_vals; $past(i_sys_rst) |-> !o_xfer_req && !o_debug_data_oe && !o_outputs_disabled; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset values");
    // tdo moves only once the falling pin edge has been synchronised
    property p_tdo_fall; $changed(o_debug_data_out) |-> !$past(i_debug_clock_pin, 2); endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved outside low clock phase");
    c_xfer: cover property (o_xfer_req && i_xfer_done);
    c_gate: cover property ($rose(o_outputs_disabled));
    c_shift: cover property (o_debug_data_oe);
endmodule

bind dbg_access_top dbg_access_properties i_dbg_access_properties (
    .i_ref_clk, .i_sys_rst, .i_hsel, .i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_debug_clock_pin, .o_debug_data_out, .o_outputs_disabled, .o_debug_data_oe,
    .i_trigger, .i_xfer_done, .o_xfer_req, .o_xfer_src_addr, .o_xfer_size
);

// file: tb/dbg_tool_model.sv
// debug tool model driving the serial debug port pins
// assumes calls come between bus accesses; debug clock idles low
`timescale 1ns/1ns
module dbg_tool_model (
    // pins toward the device
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // 800 ns bit; tdo taken late in the high half, before the next fall
    task automatic tbit(input logic ms, input logic di, output logic dout);
        o_tms = ms;
        o_tdi = di;
        #400 o_tck = 1'b1;
        #390 dout = i_tdo;
        #10 o_tck = 1'b0;
    endtask
    task automatic scan_ir(input int n, input logic [15:0] d, output logic [15:0] q);
        logic t;
        q = 16'h0;
        #37;
        tbit(1'b0, 1'b0, t);
        tbit(1'b1, 1'b0, t);
        tbit(1'b1, 1'b0, t);
        tbit(1'b0, 1'b0, t);
        tbit(n == 0, 1'b0, t);
        for (int i = 0; i < n; i++) begin
            tbit(i == n - 1, d[i], t);
            q[i] = t;
        end
        tbit(1'b1, 1'b0, t);
        tbit(1'b0, 1'b0, t);
        // no stale level left on the data line between frames
        o_tdi = ~o_tdi;
    endtask
    task automatic pulse();
        logic t;
        #37;
        tbit(1'b0, 1'b0, t);
    endtask
endmodule

// file: tb/dbg_access_top_bench.sv
// self-checking bench for the debug access block
// assumes the tool model on the pins and the bench as bus master
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module dbg_access_top_bench;
    import dbg_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} dbg_row_t;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        hsel = 1'b0, hwrite = 1'b0, app_rst = 1'b0, trig = 1'b0, done = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, xrdata = 32'h0, rd, hrdata, src, dst;
    logic        hready, hresp, tck, tms, tdi, tdo, oe, out_dis, req;
    logic [2:0]  size;
    logic [15:0] q;
    int          fails = 0, check_count = 0, i;
    dbg_row_t    rows [16];
    always #50 i_ref_clk = ~i_ref_clk;
    dbg_access_top i_dbg_access_top (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_debug_clock_pin(tck), .i_debug_mode_pin(tms), .i_debug_data_pin(tdi), .o_debug_data_out(tdo),
        .o_debug_data_oe(oe), .o_outputs_disabled(out_dis), .i_app_rst(app_rst), .i_trigger(trig),
        .i_xfer_done(done), .i_xfer_rdata(xrdata), .o_xfer_req(req), .o_xfer_src_addr(src),
        .o_xfer_dst_addr(dst), .o_xfer_size(size));
    dbg_tool_model i_dbg_tool_model (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
    // entered just after a rising edge; holds each phase until hready
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= DBG_SIZE_WORD;
        do @(posedge i_ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        stop_test();
    end
    initial begin
        rows = '{'{1'b0, 8'h00, 32'h0, 32'h2}, '{1'b0, 8'h04, 32'h0, 32'h7fc}, '{1'b0, 8'h08, 32'h0, 32'h0},
            '{1'b0, 8'h0c, 32'h0, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b0, 8'h14, 32'h0, 32'h0},
            '{1'b0, 8'h18, 32'h0, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h10, 32'h12345678, 32'h0},
            '{1'b1, 8'h14, 32'habc0, 32'h0}, '{1'b1, 8'h18, 32'hffff, 32'h0}, '{1'b1, 8'h20, 32'h55, 32'h0},
            '{1'b0, 8'h10, 32'h0, 32'h12345678}, '{1'b0, 8'h14, 32'h0, 32'habc0}, '{1'b0, 8'h18, 32'h0, 32'h0},
            '{1'b0, 8'h20, 32'h0, 32'h0}};
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        for (i = 0; i < 16; i++) begin
            ahb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) `CHK(rd, rows[i].e)
        end
        $display("test registers done");
        i_dbg_tool_model.scan_ir(8, 16'h5a, q);
        @(posedge i_ref_clk);
        `CHK(q[7:0], 8'h01)
        ahb(1'b0, DBG_STAT_OFS, 32'h0);
        `CHK(rd[10:0], {8'h5a, 3'h1})
        i_dbg_tool_model.scan_ir(12, 16'habc, q);
        @(posedge i_ref_clk);
        `CHK(q[11:0], 12'hc01)
        ahb(1'b0, DBG_STAT_OFS, 32'h0);
        `CHK(rd[10:3], 8'hab)
        $display("test instruction scan done");
        i_dbg_tool_model.scan_ir(0, 16'h0, q);
        @(posedge i_ref_clk);
        ahb(1'b0, DBG_STAT_OFS, 32'h0);
        `CHK(rd[11:3], 9'h001)
        `CHK(out_dis, 1'b0)
        ahb(1'b1, DBG_CTRL_OFS, 32'h0);
        // the output gate flop trails the lock write by one cycle
        @(posedge i_ref_clk);
        ahb(1'b0, DBG_STAT_OFS, 32'h0);
        `CHK(rd[11], 1'b1)
        `CHK(out_dis, 1'b1)
        ahb(1'b1, DBG_CTRL_OFS, 32'h2);
        ahb(1'b0, DBG_CTRL_OFS, 32'h0);
        `CHK(out_dis, 1'b0)
        $display("test lock done");
        ahb(1'b1, DBG_CTRL_OFS, 32'h3);
        ahb(1'b0, DBG_STAT_OFS, 32'h0);
        `CHK(rd[2:0], 3'h1)
        i_dbg_tool_model.pulse();
        @(posedge i_ref_clk);
        ahb(1'b0, DBG_STAT_OFS, 32'h0);
        `CHK(rd[10:0], 11'h7fc)
        ahb(1'b1, DBG_CTRL_OFS, 32'h2);
        $display("test restart done");
        ahb(1'b1, DBG_CMD_OFS, 32'h1);
        ahb(1'b1, DBG_CMD_OFS, 32'h0302);
        ahb(1'b0, DBG_CONF_OFS, 32'h0);
        `CHK(rd[1:0], 2'h3)
        trig <= 1'b1;
        @(posedge i_ref_clk);
        trig <= 1'b0;
        for (i = 0; i < 20 && req !== 1'b1; i++) @(posedge i_ref_clk);
        `CHK({req, size, src, dst}, {1'b1, DBG_SIZE_WORD, 32'h12345678, 32'habc0})
        trig <= 1'b1;
        @(posedge i_ref_clk);
        trig <= 1'b0;
        done <= 1'b1;
        xrdata <= 32'hcafef00d;
        @(posedge i_ref_clk);
        done <= 1'b0;
        ahb(1'b1, DBG_CMD_OFS, 32'h3);
        ahb(1'b0, DBG_DATA_OFS, 32'h0);
        `CHK(rd, 32'hcafef00d)
        ahb(1'b0, DBG_INFO_OFS, 32'h0);
        `CHK({rd[4], rd[2]}, 2'h2)
        ahb(1'b1, DBG_CMD_OFS, 32'h4); // read-trigger after a dirty read, which a tool avoids
        ahb(1'b0, DBG_INFO_OFS, 32'h0);
        `CHK(rd[2], 1'b1)
        $display("test transfer done");
        app_rst <= 1'b1;
        @(posedge i_ref_clk);
        app_rst <= 1'b0;
        @(posedge i_ref_clk);
        ahb(1'b0, DBG_CONF_OFS, 32'h0);
        `CHK(rd[1:0], 2'h0)
        ahb(1'b0, DBG_INFO_OFS, 32'h0);
        `CHK(rd[1:0], 2'h3)
        ahb(1'b1, DBG_CMD_OFS, 32'h0302);
        ahb(1'b0, DBG_CONF_OFS, 32'h0);
        `CHK(rd[1:0], 2'h0)
        ahb(1'b1, DBG_CMD_OFS, 32'h1);
        ahb(1'b1, DBG_CMD_OFS, 32'h0302);
        ahb(1'b1, DBG_INFO_OFS, 32'h2);
        ahb(1'b0, DBG_CONF_OFS, 32'h0);
        `CHK(rd[1:0], 2'h3)
        ahb(1'b0, DBG_INFO_OFS, 32'h0);
        `CHK(rd[1:0], 2'h0)
        $display("test application reset done");
        stop_test();
    end
endmodule
